/* File: common/jlit_pkg.sv */
package jlit_pkg;
	localparam int JLIT_SAMPLE_W = 16;
	localparam int JLIT_FIFO_DEPTH = 32;
	// frame clock cycles from internal boundary to serial output
	localparam int JLIT_OUT_DELAY = 6;
	localparam int JLIT_OUT_DELAY_MIN = 5;
	localparam int JLIT_OUT_DELAY_MAX = 7;
	localparam int JLIT_SYNC_SETUP = 3;
	localparam int JLIT_SYNC_HOLD = 0;
	localparam int JLIT_RESYNC_HOLD = 4;
	localparam int JLIT_SYSREF_MIN = 2;
	localparam logic [1:0] JLIT_ILA_LAST_MF = 2'h3;
	localparam logic [5:0] JLIT_K_MAX = 6'h20;
	localparam logic [4:0] JLIT_K_LAST_MAX = 5'h1f;
	// frame clock equals sample clock; one 16-bit frame per cycle
	localparam int JLIT_CLOCK_MHZ = 100;
	localparam int JLIT_FRAME_LINE_BITS = 20;
	localparam int JLIT_LANE_MBPS = JLIT_CLOCK_MHZ * JLIT_FRAME_LINE_BITS;
	localparam int JLIT_LANE_MIN_MBPS = 1000;
	localparam int JLIT_LANE_MAX_MBPS = 7400;
	localparam logic [7:0] JLIT_K28_5 = 8'hbc;
	localparam logic [7:0] JLIT_K28_0 = 8'h1c;
	localparam logic [7:0] JLIT_K28_3 = 8'h7c;
	localparam logic [1:0] JLIT_K_BOTH = 2'h3;
	localparam logic [1:0] JLIT_K_HIGH = 2'h2;
	localparam logic [1:0] JLIT_K_NONE = 2'h0;

	typedef enum logic [1:0] {
		JLIT_CGS = 2'b00,
		JLIT_ILA = 2'b01,
		JLIT_DATA = 2'b10
	} jlit_link_state_type;

	typedef struct packed {
		logic [1:0] k;
		logic [15:0] data;
	} jlit_frame_type;

	// zero or above the maximum falls back to the default of 32
	function automatic logic [4:0] jlit_k_last(input logic [5:0] cfg);
		if (cfg == 6'h00 || cfg > JLIT_K_MAX) begin
			return JLIT_K_LAST_MAX;
		end
		return 5'(cfg - 6'h01);
	endfunction : jlit_k_last
endpackage : jlit_pkg

/* File: rtl/jlit_fifo.sv */
`timescale 1ns/100ps
module jlit_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [CW-1:0] count;
		logic ready;
	} jlit_fifo_state_type;

	jlit_fifo_state_type q;
	jlit_fifo_state_type next_q;
	logic push;
	logic pop;

	function automatic logic [AW-1:0] jlit_wrap(input logic [AW-1:0] p);
		if (p == AW'(DEPTH - 1)) begin
			return '0;
		end
		return AW'(p + 1'b1);
	endfunction : jlit_wrap

	assign in_ready = q.ready;
	assign out_valid = q.count != '0;
	assign out_data = q.mem[q.rd];

	always_comb begin
		next_q = q;
		push = in_valid & q.ready;
		pop = out_ready & (q.count != '0);
		if (push) begin
			next_q.mem[q.wr] = in_data;
			next_q.wr = jlit_wrap(q.wr);
		end
		if (pop) begin
			next_q.rd = jlit_wrap(q.rd);
		end
		case ({push, pop})
			2'b10: next_q.count = CW'(q.count + 1'b1);
			2'b01: next_q.count = CW'(q.count - 1'b1);
			default: next_q.count = q.count;
		endcase
		// registered so the source sees back-pressure without a gate
		next_q.ready = next_q.count != CW'(DEPTH);
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			q <= '0;
			q.ready <= 1'b1;
		end else begin
			q <= next_q;
		end
	end
endmodule : jlit_fifo

/* File: rtl/jlit_tx.sv */
`timescale 1ns/100ps
module jlit_tx
	import jlit_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic sysref,
	input wire logic link_sync_request_n,
	input wire logic [5:0] frames_per_multiframe,
	input wire logic sample_valid,
	output logic sample_ready,
	input wire logic [JLIT_SAMPLE_W-1:0] sample_data,
	output jlit_frame_type lane_frame,
	output jlit_link_state_type link_state
);
	typedef struct packed {
		logic [1:0] sysref_sync;
		logic sysref_last;
		logic [1:0] syncn_sync;
		logic [4:0] lmfc;
		logic pending;
		jlit_link_state_type state;
		logic [1:0] ila_mf;
		jlit_frame_type [JLIT_OUT_DELAY-1:0] pipe;
	} jlit_tx_state_type;

	jlit_tx_state_type q;
	jlit_tx_state_type next_q;
	logic [4:0] k_last;
	logic sysref_rise;
	logic sync_n;
	logic boundary;
	logic pop;
	logic fifo_valid;
	logic [JLIT_SAMPLE_W-1:0] fifo_data;
	jlit_frame_type frame;
	logic enter_cgs;
	logic enter_ila;
	logic enter_data;

	jlit_fifo #(
		.WIDTH(JLIT_SAMPLE_W),
		.DEPTH(JLIT_FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.sys_rst(sys_rst),
		.in_valid(sample_valid),
		.in_ready(sample_ready),
		.in_data(sample_data),
		.out_valid(fifo_valid),
		.out_ready(pop),
		.out_data(fifo_data)
	);

	assign lane_frame = q.pipe[JLIT_OUT_DELAY-1];
	assign link_state = q.state;
	assign k_last = jlit_k_last(frames_per_multiframe);
	// sysref pulse width is the sender's duty; one rising edge rephases
	assign sysref_rise = q.sysref_sync[1] & ~q.sysref_last;
	assign sync_n = q.syncn_sync[1];
	assign boundary = q.lmfc == 5'h00;

	always_comb begin
		next_q = q;
		frame = '0;
		pop = 1'b0;
		next_q.sysref_sync = {q.sysref_sync[0], sysref};
		next_q.sysref_last = q.sysref_sync[1];
		next_q.syncn_sync = {q.syncn_sync[0], link_sync_request_n};
		if (sysref_rise || q.lmfc >= k_last) begin
			next_q.lmfc = 5'h00;
		end else begin
			next_q.lmfc = 5'(q.lmfc + 5'h01);
		end
		// a short low pulse between boundaries is remembered; set wins
		next_q.pending = ~sync_n | (q.pending & ~boundary);
		// state only moves on the boundary; sync is sampled there, and a low between boundaries is held in pending
		if (boundary) begin
			case (q.state)
				JLIT_CGS: begin
					if (sync_n) begin
						next_q.state = JLIT_ILA;
						next_q.ila_mf = 2'h0;
					end
				end
				JLIT_ILA: begin
					if (~sync_n || q.pending) begin
						next_q.state = JLIT_CGS;
					end else if (q.ila_mf == JLIT_ILA_LAST_MF) begin
						next_q.state = JLIT_DATA;
					end else begin
						next_q.ila_mf = 2'(q.ila_mf + 2'h1);
					end
				end
				JLIT_DATA: begin
					if (~sync_n || q.pending) begin
						next_q.state = JLIT_CGS;
					end
				end
				default: next_q.state = JLIT_CGS;
			endcase
		end
		// frame follows the new state so a change shows from its boundary
		case (next_q.state)
			JLIT_CGS: begin
				frame.k = JLIT_K_BOTH;
				frame.data = {JLIT_K28_5, JLIT_K28_5};
			end
			JLIT_ILA: begin
				if (q.lmfc == 5'h00) begin
					frame.k = JLIT_K_HIGH;
					frame.data = {JLIT_K28_0, 3'h0, q.lmfc};
				end else if (q.lmfc == k_last) begin
					frame.k = JLIT_K_HIGH;
					frame.data = {JLIT_K28_3, 3'h0, q.lmfc};
				end else begin
					frame.k = JLIT_K_NONE;
					frame.data = {3'h0, q.lmfc, 6'h00, next_q.ila_mf};
				end
			end
			JLIT_DATA: begin
				// underrun sends a zero frame rather than stalling the lane
				pop = fifo_valid;
				frame.k = JLIT_K_NONE;
				frame.data = fifo_valid ? fifo_data : 16'h0000;
			end
			default: frame = '0;
		endcase
		// fixed output latency from boundary to serial output
		next_q.pipe = {q.pipe[JLIT_OUT_DELAY-2:0], frame};
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign enter_cgs = boundary && q.state != JLIT_CGS
		&& next_q.state == JLIT_CGS;
	assign enter_ila = boundary && q.state == JLIT_CGS
		&& next_q.state == JLIT_ILA;
	assign enter_data = boundary && q.state == JLIT_ILA
		&& next_q.state == JLIT_DATA;

	sequence s_comma_out;
		##6 (lane_frame.k == JLIT_K_BOTH
			&& lane_frame.data == {JLIT_K28_5, JLIT_K28_5});
	endsequence

	sequence s_align_start_out;
		##6 (lane_frame.k == JLIT_K_HIGH
			&& lane_frame.data[15:8] == JLIT_K28_0);
	endsequence

	property p_comma_delay;
		@(posedge clock) disable iff (sys_rst)
		enter_cgs |-> s_comma_out;
	endproperty
	a_comma_delay: assert property (p_comma_delay)
		else $error("first comma not 6 frames after boundary");

	property p_align_delay;
		@(posedge clock) disable iff (sys_rst)
		enter_ila |-> s_align_start_out;
	endproperty
	a_align_delay: assert property (p_align_delay)
		else $error("first alignment frame not 6 after boundary");

	property p_data_delay;
		@(posedge clock) disable iff (sys_rst)
		enter_data |-> ##6 (lane_frame.k == JLIT_K_NONE
			&& $past(q.state, 5) == JLIT_DATA);
	endproperty
	a_data_delay: assert property (p_data_delay)
		else $error("first data frame not 6 after boundary");

	property p_sync_sampled;
		@(posedge clock) disable iff (sys_rst)
		boundary && q.state == JLIT_CGS && sync_n |=> q.state == JLIT_ILA;
	endproperty
	a_sync_sampled: assert property (p_sync_sampled)
		else $error("released sync not taken at boundary");

	property p_hold_off_boundary;
		@(posedge clock) disable iff (sys_rst)
		!boundary |=> $stable(q.state);
	endproperty
	a_hold_off_boundary: assert property (p_hold_off_boundary)
		else $error("link state moved off a boundary");

	property p_resync_latched;
		@(posedge clock) disable iff (sys_rst)
		!sync_n && q.state == JLIT_DATA |=> q.pending
			|| q.state == JLIT_CGS;
	endproperty
	a_resync_latched: assert property (p_resync_latched)
		else $error("sync request during data lost");

	property p_align_length;
		@(posedge clock) disable iff (sys_rst)
		enter_data |-> q.ila_mf == JLIT_ILA_LAST_MF
			&& $past(q.state, 1) == JLIT_ILA;
	endproperty
	a_align_length: assert property (p_align_length)
		else $error("alignment not four multiframes");

	property p_lane_rate;
		@(posedge clock) disable iff (sys_rst)
		JLIT_LANE_MBPS >= JLIT_LANE_MIN_MBPS
			&& JLIT_LANE_MBPS <= JLIT_LANE_MAX_MBPS;
	endproperty
	a_lane_rate: assert property (p_lane_rate)
		else $error("lane rate outside range");

	property p_one_frame;
		@(posedge clock) disable iff (sys_rst)
		next_q.state == JLIT_DATA && fifo_valid |-> pop;
	endproperty
	a_one_frame: assert property (p_one_frame)
		else $error("sample not sent in its frame");

	property p_lmfc_wrap;
		@(posedge clock) disable iff (sys_rst)
		q.lmfc == k_last && !sysref_rise && $stable(k_last)
			|=> boundary;
	endproperty
	a_lmfc_wrap: assert property (p_lmfc_wrap)
		else $error("multiframe length wrong");

	property p_comma_hold;
		@(posedge clock) disable iff (sys_rst)
		next_q.state == JLIT_CGS |-> s_comma_out;
	endproperty
	a_comma_hold: assert property (p_comma_hold)
		else $error("non-comma sent while synchronising");

	property p_resync_return;
		@(posedge clock) disable iff (sys_rst)
		boundary && q.state == JLIT_DATA && q.pending
			|=> q.state == JLIT_CGS ##1 !boundary [*1];
	endproperty
	a_resync_return: assert property (p_resync_return)
		else $error("data did not fall back to commas");
endmodule : jlit_tx

/* File: tb/jlit_rx_model.sv */
`timescale 1ns/100ps
module jlit_rx_model
	import jlit_pkg::*;
(
	input wire logic clock,
	input wire logic want_sync,
	output logic link_sync_request_n
);
	int low_count;

	// powers up requesting sync, as a receiver out of reset does
	initial begin
		link_sync_request_n = 1'b0;
		low_count = 0;
	end

	// level moves only on command, and a low then stands at least 4 frames
	always @(posedge clock) begin
		// a short command is stretched so it still forces resync
		if (want_sync || (!link_sync_request_n &&
				low_count < JLIT_RESYNC_HOLD)) begin
			link_sync_request_n <= 1'b0;
			low_count <= low_count + 1;
		end else begin
			link_sync_request_n <= 1'b1;
			low_count <= 0;
		end
	end
endmodule : jlit_rx_model

/* File: tb/jesd_link_init_timing_test.sv */
`timescale 1ns/100ps
module jesd_link_init_timing_test;
	import jlit_pkg::*;
	logic clock, sys_rst, sysref, want_sync, sample_valid, sample_ready;
	logic link_sync_request_n;
	logic [5:0] frames_per_multiframe;
	logic [JLIT_SAMPLE_W-1:0] sample_data;
	jlit_frame_type lane_frame;
	jlit_link_state_type link_state;
	int fails, check_count, k;
	logic [15:0] sent[$];
	logic [5:0] cfgs[4];
	localparam jlit_frame_type COMMA = {JLIT_K_BOTH, JLIT_K28_5, JLIT_K28_5};

	jlit_tx dut_u (.clock(clock), .sys_rst(sys_rst), .sysref(sysref),
		.link_sync_request_n(link_sync_request_n),
		.frames_per_multiframe(frames_per_multiframe),
		.sample_valid(sample_valid), .sample_ready(sample_ready),
		.sample_data(sample_data), .lane_frame(lane_frame),
		.link_state(link_state));
	jlit_rx_model model_u (.clock(clock), .want_sync(want_sync),
		.link_sync_request_n(link_sync_request_n));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task complete_run;
		if (fails == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run

	task check_frame(input jlit_frame_type exp);
		check_count++;
		if (lane_frame !== exp) begin
			fails++;
			$display("mismatch %0t frame %h want %h", $time, lane_frame, exp);
		end
	endtask : check_frame

	task check_state(input jlit_link_state_type exp);
		check_count++;
		if (link_state !== exp) begin
			fails++;
			$display("mismatch %0t state %b want %b", $time, link_state, exp);
		end
	endtask : check_state

	task cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : cyc

	// bounded so a stuck link shows as a state mismatch
	task wait_state(input jlit_link_state_type s);
		int i;
		i = 0;
		while (link_state !== s && i < 2000) begin
			cyc(1);
			i++;
		end
		check_state(s);
	endtask : wait_state

	function automatic jlit_frame_type ila_frame(input int pos, input int mf);
		if (pos == 0)
			return {JLIT_K_HIGH, JLIT_K28_0, 8'(pos)};
		if (pos == k - 1)
			return {JLIT_K_HIGH, JLIT_K28_3, 8'(pos)};
		return {JLIT_K_NONE, 8'(pos), 8'(mf)};
	endfunction : ila_frame

	// entered at the first alignment frame; leaves at the first data frame
	task check_ila;
		for (int i = 0; i < 4 * k; i++) begin
			check_frame(ila_frame(i % k, i / k));
			if (i == 4 * k - 6)
				check_state(JLIT_ILA);
			cyc(1);
		end
		check_state(JLIT_DATA);
	endtask : check_ila

	task run_link(input logic [5:0] cfg);
		sys_rst = 1'b1;
		want_sync = 1'b1;
		frames_per_multiframe = cfg;
		k = (cfg == 6'h00 || cfg > JLIT_K_MAX) ? 32 : int'(cfg);
		cyc(12);
		sys_rst = 1'b0;
		cyc(1);
		check_state(JLIT_CGS);
		check_frame('0);
		cyc(8);
		check_frame(COMMA);
		sysref = 1'b1;
		cyc(2);
		sysref = 1'b0;
		cyc(2);
		// fill until refused; the fifo holds while commas are sent
		while (sample_ready === 1'b1 && sent.size() < 40) begin
			sample_valid = 1'b1;
			sample_data = 16'($urandom);
			sent.push_back(sample_data);
			cyc(1);
		end
		sample_valid = 1'b0;
		if (sent.size() != JLIT_FIFO_DEPTH)
			check_frame({2'h3, 16'hffff});
		cyc(2 * k);
		check_state(JLIT_CGS);
		check_frame(COMMA);
		want_sync = 1'b0;
		wait_state(JLIT_ILA);
		cyc(5);
		check_ila;
		foreach (sent[i]) begin
			check_frame({JLIT_K_NONE, sent[i]});
			cyc(1);
		end
		check_frame('0);
		want_sync = 1'b1;
		cyc(1);
		want_sync = 1'b0;
		wait_state(JLIT_CGS);
		cyc(8);
		check_frame(COMMA);
		wait_state(JLIT_ILA);
		cyc(5);
		check_ila;
		sent.delete();
	endtask : run_link

	initial begin
		sys_rst = 1'b1;
		sysref = 1'b0;
		want_sync = 1'b1;
		sample_valid = 1'b0;
		sample_data = '0;
		frames_per_multiframe = 6'h20;
		fails = 0;
		check_count = 0;
		void'($urandom(32'he733));
		// 9 frames is the shortest legal multiframe; the resync checks
		// need the next boundary at least 4 frames after the fall-back
		cfgs[0] = 6'($urandom_range(9, 31));
		cfgs[1] = 6'h20;
		cfgs[2] = 6'h00;
		cfgs[3] = 6'h28;
		@(posedge clock);
		#1;
		foreach (cfgs[i])
			run_link(cfgs[i]);
		complete_run;
	end

	// generous against roughly 2000 cycles of work
	initial begin
		#200000;
		fails++;
		complete_run;
	end
endmodule : jesd_link_init_timing_test
